// ===== rtl/ftsb_status_bank.sv
// regulator fault and thermal hot status bank with register read and clear
`timescale 1ns/1ps
`default_nettype none

module ftsb_status_bank
  import ftsb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port from the serial transport
  input wire ftsb_req_s req,
  output ftsb_reg_t rdata,
  output logic rvalid,
  // asynchronous detector levels
  input wire ftsb_loss_s loss,
  input wire logic [HOT_SENSORS-1:0] sensor_hot
);

  // raw detector levels gathered for the synchronisers
  logic [SENSE_W-1:0] sense_raw;
  logic sense_meta [SENSE_W];
  logic sense_sync [SENSE_W];
  logic [HOT_SENSORS-1:0] hot_sync_v;

  // set, clear and flag vectors
  ftsb_reg_t fault_set;
  ftsb_reg_t hot_set;
  ftsb_reg_t fault_clr;
  ftsb_reg_t hot_clr;
  ftsb_reg_t fault_flags;
  ftsb_reg_t hot_flags;

  // decode and read selection
  logic hit_fault;
  logic hit_hot;
  ftsb_reg_t next_rdata;

  // detector levels arrive from analog, in no relation to clk
  assign sense_raw = {sensor_hot,
                      loss.first_aux_regulator_fault,
                      loss.termination_regulator_fault,
                      loss.third_aux_regulator_fault};

  // two-flop synchroniser per detector; first stage feeds only the second
  genvar gi;
  generate
    for (gi = 0; gi < SENSE_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sense_meta[gi] <= 1'b0;
          sense_sync[gi] <= 1'b0;
        end else begin
          sense_meta[gi] <= sense_raw[gi];
          sense_sync[gi] <= sense_meta[gi];
        end
      end
    end
    // one hot flag per sensor, in sensor order
    for (gi = 0; gi < HOT_SENSORS; gi++) begin : g_hot
      assign hot_sync_v[gi] = sense_sync[SENSE_HOT_BASE + gi];
    end
  endgenerate

  // regulator losses placed on their register bits
  assign fault_set = ((ftsb_reg_t'(sense_sync[SENSE_FIRST_AUX]) << FAULT_FIRST_AUX_BIT)
                    | (ftsb_reg_t'(sense_sync[SENSE_TERM]) << FAULT_TERM_BIT)
                    | (ftsb_reg_t'(sense_sync[SENSE_THIRD_AUX]) << FAULT_THIRD_AUX_BIT))
                    & FAULT_MASK;

  // sensor order already matches bits 4 down to 0
  assign hot_set = {3'h0, hot_sync_v} & HOT_MASK;

  // address decode
  assign hit_fault = (req.addr == FAULT_ADDR);
  assign hit_hot = (req.addr == HOT_ADDR);

  // write one clears; zeros and reserved bits have no effect
  assign fault_clr = (req.wr && hit_fault) ? (req.wdata & FAULT_MASK) : STATUS_RESET;
  assign hot_clr = (req.wr && hit_hot) ? (req.wdata & HOT_MASK) : STATUS_RESET;

  // fault latches; a level still present re-sets on the clear cycle
  ftsb_sticky_bank u_fault_bank (
    .clk(clk),
    .srst(srst),
    .set(fault_set),
    .clr(fault_clr),
    .flags(fault_flags)
  );

  // thermal latches
  ftsb_sticky_bank u_hot_bank (
    .clk(clk),
    .srst(srst),
    .set(hot_set),
    .clr(hot_clr),
    .flags(hot_flags)
  );

  // read select; unmapped offsets read zero
  assign next_rdata = hit_fault ? fault_flags : (hit_hot ? hot_flags : STATUS_RESET);

  // read data held until the next read so the transport can shift it out slowly
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= STATUS_RESET;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= next_rdata;
      end
    end
  end

  // a fault level held for three edges is seen in the flag
  aux1_fault_set_a: assert property (
    @(posedge clk) disable iff (srst)
    loss.first_aux_regulator_fault |-> ##3 fault_flags[FAULT_FIRST_AUX_BIT]
  ) else $error("first aux fault not latched");

  term_fault_set_a: assert property (
    @(posedge clk) disable iff (srst)
    loss.termination_regulator_fault |-> ##3 fault_flags[FAULT_TERM_BIT]
  ) else $error("termination fault not latched");

  aux3_fault_set_a: assert property (
    @(posedge clk) disable iff (srst)
    loss.third_aux_regulator_fault |-> ##3 fault_flags[FAULT_THIRD_AUX_BIT]
  ) else $error("third aux fault not latched");

  // a flag never rises without its detector three edges before
  fault_no_spurious_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(fault_flags[FAULT_FIRST_AUX_BIT]) |-> $past(loss.first_aux_regulator_fault, 3)
  ) else $error("first aux fault set with no cause");

  // fault flag holds unless a one is written to it
  fault_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    fault_flags[FAULT_TERM_BIT] && !(req.wr && hit_fault && req.wdata[FAULT_TERM_BIT])
    |=> fault_flags[FAULT_TERM_BIT]
  ) else $error("termination fault dropped without clear");

  // a clear with the condition gone empties the flag
  fault_clear_a: assert property (
    @(posedge clk) disable iff (srst)
    req.wr && hit_fault && req.wdata[FAULT_FIRST_AUX_BIT] && !fault_set[FAULT_FIRST_AUX_BIT]
    |=> !fault_flags[FAULT_FIRST_AUX_BIT]
  ) else $error("first aux fault not cleared");

  // rest-of-die and termination sensors land on their own hot bits, top-right only checked together with bottom-right
  hot_die_set_a: assert property (
    @(posedge clk) disable iff (srst)
    sensor_hot[HOT_REST_OF_DIE_BIT] |-> ##3 hot_flags[HOT_REST_OF_DIE_BIT]
  ) else $error("rest of die hot not latched");

  hot_term_set_a: assert property (
    @(posedge clk) disable iff (srst)
    sensor_hot[HOT_TERM_BIT] |-> ##3 hot_flags[HOT_TERM_BIT]
  ) else $error("termination hot not latched");

  hot_corner_set_a: assert property (
    @(posedge clk) disable iff (srst)
    sensor_hot[HOT_TOP_RIGHT_BIT] && sensor_hot[HOT_BOTTOM_RIGHT_BIT]
    |-> ##3 hot_flags[HOT_TOP_RIGHT_BIT] && hot_flags[HOT_BOTTOM_RIGHT_BIT]
  ) else $error("corner hot not latched");

  // top-left flag never rises without its own sensor three edges before
  hot_left_only_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(hot_flags[HOT_TOP_LEFT_BIT]) |-> $past(sensor_hot[HOT_TOP_LEFT_BIT], 3)
  ) else $error("top-left hot set with no cause");

  // a read alone never clears a hot flag
  hot_read_keep_a: assert property (
    @(posedge clk) disable iff (srst)
    hot_flags[HOT_TOP_LEFT_BIT] && req.rd && !req.wr
    |=> hot_flags[HOT_TOP_LEFT_BIT]
  ) else $error("hot flag cleared by read");

  // reserved fault and hot bits stay zero on every read
  fault_reserved_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && hit_fault |=> rvalid && ((rdata & ~FAULT_MASK) == STATUS_RESET)
  ) else $error("reserved fault bits read nonzero");

  hot_reserved_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && hit_hot |=> rvalid && (rdata[7:5] == 3'h0)
  ) else $error("reserved hot bits read nonzero");

  // both registers read back zero right after reset
  reset_zero_a: assert property (
    @(posedge clk)
    srst |=> (fault_flags == STATUS_RESET) && (hot_flags == STATUS_RESET)
  ) else $error("status not zero after reset");

  // writing zero leaves the flag alone
  zero_write_keep_a: assert property (
    @(posedge clk) disable iff (srst)
    hot_flags[HOT_REST_OF_DIE_BIT] && req.wr && hit_hot && !req.wdata[HOT_REST_OF_DIE_BIT]
    |=> hot_flags[HOT_REST_OF_DIE_BIT]
  ) else $error("zero write changed hot flag");

  // a clear that meets a live condition leaves the flag set
  clear_loses_a: assert property (
    @(posedge clk) disable iff (srst)
    req.wr && hit_fault && req.wdata[FAULT_THIRD_AUX_BIT] && fault_set[FAULT_THIRD_AUX_BIT]
    |=> fault_flags[FAULT_THIRD_AUX_BIT]
  ) else $error("live fault lost on clear");

  // remaining corner sensors land on their own hot bits
  bottom_hot_set_a: assert property (
    @(posedge clk) disable iff (srst)
    sensor_hot[HOT_BOTTOM_RIGHT_BIT] |-> ##3 hot_flags[HOT_BOTTOM_RIGHT_BIT]
  ) else $error("bottom-right hot not latched");

  left_hot_set_a: assert property (
    @(posedge clk) disable iff (srst)
    sensor_hot[HOT_TOP_LEFT_BIT] |-> ##3 hot_flags[HOT_TOP_LEFT_BIT]
  ) else $error("top-left hot not latched");

  // other fault flags never rise without their own detector
  term_no_cause_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(fault_flags[FAULT_TERM_BIT]) |-> $past(loss.termination_regulator_fault, 3)
  ) else $error("termination fault set with no cause");

  aux3_no_cause_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(fault_flags[FAULT_THIRD_AUX_BIT]) |-> $past(loss.third_aux_regulator_fault, 3)
  ) else $error("third aux fault set with no cause");

  // rest-of-die flag needs its own sensor, not a neighbour
  die_no_cause_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(hot_flags[HOT_REST_OF_DIE_BIT]) |-> $past(sensor_hot[HOT_REST_OF_DIE_BIT], 3)
  ) else $error("rest of die hot set with no cause");

  // termination hot flag needs the sensor at that regulator
  term_hot_cause_a: assert property (
    @(posedge clk) disable iff (srst)
    $rose(hot_flags[HOT_TERM_BIT]) |-> $past(sensor_hot[HOT_TERM_BIT], 3)
  ) else $error("termination hot set with no cause");

  // hot flag holds unless a one is written to it
  hot_hold_a: assert property (
    @(posedge clk) disable iff (srst)
    hot_flags[HOT_TERM_BIT] && !(req.wr && hit_hot && req.wdata[HOT_TERM_BIT])
    |=> hot_flags[HOT_TERM_BIT]
  ) else $error("termination hot dropped without clear");

  // a clear with the sensor cool empties the flag
  hot_clear_a: assert property (
    @(posedge clk) disable iff (srst)
    req.wr && hit_hot && req.wdata[HOT_BOTTOM_RIGHT_BIT] && !hot_set[HOT_BOTTOM_RIGHT_BIT]
    |=> !hot_flags[HOT_BOTTOM_RIGHT_BIT]
  ) else $error("bottom-right hot not cleared");

  // a zero written to the fault register keeps the flag
  fault_zero_keep_a: assert property (
    @(posedge clk) disable iff (srst)
    fault_flags[FAULT_THIRD_AUX_BIT] && req.wr && hit_fault
    && !req.wdata[FAULT_THIRD_AUX_BIT] |=> fault_flags[FAULT_THIRD_AUX_BIT]
  ) else $error("zero write changed fault flag");

  // writes to other offsets never touch the flags
  stray_write_keep_a: assert property (
    @(posedge clk) disable iff (srst)
    req.wr && !hit_fault && !hit_hot && fault_flags[FAULT_FIRST_AUX_BIT]
    |=> fault_flags[FAULT_FIRST_AUX_BIT]
  ) else $error("stray write cleared fault flag");

  // one answer per read strobe, one edge later, and no other
  read_answer_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd |=> rvalid
  ) else $error("read not answered");

  read_quiet_a: assert property (
    @(posedge clk) disable iff (srst)
    !req.rd |=> !rvalid
  ) else $error("answer with no read");

  // read data is the register as it stood at the strobe
  fault_read_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && hit_fault |=> rdata == $past(fault_flags)
  ) else $error("fault read data wrong");

  hot_read_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && hit_hot |=> rdata == $past(hot_flags)
  ) else $error("hot read data wrong");

  // unmapped offsets read zero, keeping the transport simple
  unmapped_read_a: assert property (
    @(posedge clk) disable iff (srst)
    req.rd && !hit_fault && !hit_hot |=> rdata == STATUS_RESET
  ) else $error("unmapped read nonzero");

endmodule : ftsb_status_bank

`default_nettype wire

// ===== rtl/ftsb_pkg.sv
// package: register map, field positions and carrier types for the status bank
package ftsb_pkg;

  // register word
  typedef logic [7:0] ftsb_reg_t;

  // register offsets on the internal register port
  localparam ftsb_reg_t FAULT_ADDR = 8'hB3;
  localparam ftsb_reg_t HOT_ADDR = 8'hB5;

  // reset value shared by both status registers
  localparam ftsb_reg_t STATUS_RESET = 8'h00;

  // regulator fault register field positions
  localparam int unsigned FAULT_FIRST_AUX_BIT = 4;
  localparam int unsigned FAULT_TERM_BIT = 3;
  localparam int unsigned FAULT_THIRD_AUX_BIT = 0;
  // implemented bits; reserved bits read zero
  localparam ftsb_reg_t FAULT_MASK = 8'h19;

  // thermal register field positions
  localparam int unsigned HOT_REST_OF_DIE_BIT = 4;
  localparam int unsigned HOT_TERM_BIT = 3;
  localparam int unsigned HOT_TOP_RIGHT_BIT = 2;
  localparam int unsigned HOT_TOP_LEFT_BIT = 1;
  localparam int unsigned HOT_BOTTOM_RIGHT_BIT = 0;
  localparam ftsb_reg_t HOT_MASK = 8'h1F;

  // number of temperature sensors
  localparam int unsigned HOT_SENSORS = 5;

  // positions in the combined raw sense vector
  localparam int unsigned SENSE_THIRD_AUX = 0;
  localparam int unsigned SENSE_TERM = 1;
  localparam int unsigned SENSE_FIRST_AUX = 2;
  localparam int unsigned SENSE_HOT_BASE = 3;
  localparam int unsigned SENSE_W = 8;

  // register request from the serial transport
  typedef struct packed {
    logic wr;
    logic rd;
    ftsb_reg_t addr;
    ftsb_reg_t wdata;
  } ftsb_req_s;

  // regulation-loss levels from the analog comparators
  typedef struct packed {
    logic first_aux_regulator_fault;
    logic termination_regulator_fault;
    logic third_aux_regulator_fault;
  } ftsb_loss_s;

endpackage : ftsb_pkg

// ===== rtl/ftsb_sticky_bank.sv
// sticky write-one-to-clear flag register with set priority
`timescale 1ns/1ps
`default_nettype none

module ftsb_sticky_bank
  import ftsb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // hardware set and software clear vectors
  input wire ftsb_reg_t set,
  input wire ftsb_reg_t clr,
  // latched flags
  output ftsb_reg_t flags
);

  ftsb_reg_t next_flags;

  // set beats clear so an event landing on the clear cycle is kept
  assign next_flags = (flags & ~clr) | set;

  // flag storage
  always_ff @(posedge clk) begin
    if (srst) begin
      flags <= STATUS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

endmodule : ftsb_sticky_bank

`default_nettype wire

// ===== dv/ftsb_host_model.sv
// host-side model driving the register port of the status bank
`timescale 1ns/1ps
`default_nettype none

module ftsb_host_model
  import ftsb_pkg::*;
(
  // clock
  input wire logic clk,
  // register port toward the bank
  output ftsb_req_s req
);
  initial req = '0;

  // one request per call, held over one taking edge, then released
  task automatic access(input logic w, input logic r, input ftsb_reg_t a, input ftsb_reg_t d);
    @(posedge clk);
    #1 req = '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask : access
endmodule : ftsb_host_model

`default_nettype wire

// ===== dv/fault_thermal_status_bank_tb_top.sv
// self-checking bench for the regulator fault and thermal hot status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end

module fault_thermal_status_bank_tb_top import ftsb_pkg::*;;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sense = '0;
  ftsb_req_s req;
  ftsb_reg_t rdata;
  logic rvalid;
  ftsb_reg_t exp_q[$];
  ftsb_reg_t exp_now;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;

  // detector levels: low three bits are regulation loss, upper five the sensors
  ftsb_status_bank i_ftsb_status_bank (.clk(clk), .srst(srst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .loss(ftsb_loss_s'(sense[2:0])), .sensor_hot(sense[7:3]));
  ftsb_host_model i_ftsb_host_model (.clk(clk), .req(req));

  always #20 clk = ~clk;

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // read results are checked against the oldest noted expectation
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      exp_now = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(rdata, exp_now)
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic rd(input ftsb_reg_t a, input ftsb_reg_t e);
    exp_q.push_back(e);
    i_ftsb_host_model.access(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic wr(input ftsb_reg_t a, input ftsb_reg_t d);
    i_ftsb_host_model.access(1'b1, 1'b0, a, d);
  endtask : wr

  // level long enough to pass the two synchroniser flops
  task automatic pulse(input logic [7:0] s);
    sense = s;
    hold(4);
    sense = 8'h00;
    hold(3);
  endtask : pulse

  // register mask of each detector line
  function automatic ftsb_reg_t spot(input int i);
    return (i == 0) ? 8'h01 : (i == 1) ? 8'h08 : (i == 2) ? 8'h10 : 8'h01 << (i - 3);
  endfunction : spot

  initial begin
    ftsb_reg_t a, m, w;
    logic [7:0] s;
    void'($urandom(4800));
    hold(8);
    srst = 1'b0;
    // reset values and an unmapped read
    rd(FAULT_ADDR, STATUS_RESET);
    rd(HOT_ADDR, STATUS_RESET);
    rd(8'hB4, 8'h00);
    $display("test reset values done");
    // each detector alone: latch, survive reads and zero writes, clear by one
    for (int i = 0; i < 8; i++) begin
      a = (i < 3) ? FAULT_ADDR : HOT_ADDR;
      m = spot(i);
      pulse(8'h01 << i);
      rd(a, m);
      rd(a, m);
      wr(a, 8'h00);
      rd(a, m);
      wr(a, m);
      rd(a, 8'h00);
    end
    $display("test single flags done");
    // a clear while the losses persist leaves the flags set
    sense = 8'h03;
    hold(4);
    wr(FAULT_ADDR, 8'h09);
    rd(FAULT_ADDR, 8'h09);
    sense = 8'h00;
    hold(3);
    wr(FAULT_ADDR, 8'h09);
    rd(FAULT_ADDR, 8'h00);
    $display("test persistent condition done");
    // flags set before a mid-run reset read zero after it
    pulse(8'hFF);
    wr(8'hB4, 8'hFF);
    rd(FAULT_ADDR, FAULT_MASK);
    rd(HOT_ADDR, HOT_MASK);
    srst = 1'b1;
    hold(2);
    srst = 1'b0;
    rd(FAULT_ADDR, STATUS_RESET);
    rd(HOT_ADDR, STATUS_RESET);
    $display("test mid-run reset done");
    // random sets, partial clears, reserved bits, unmapped write, read with clear
    repeat (6) begin
      s = 8'($urandom);
      w = 8'($urandom);
      pulse(s);
      wr(8'hB4, 8'hFF);
      m = {3'b000, s[2], s[1], 2'b00, s[0]};
      wr(FAULT_ADDR, w);
      rd(FAULT_ADDR, m & ~w);
      m = {3'b000, s[7:3]};
      exp_q.push_back(m);
      i_ftsb_host_model.access(1'b1, 1'b1, HOT_ADDR, w);
      rd(HOT_ADDR, m & ~w);
      wr(FAULT_ADDR, 8'hFF);
      wr(HOT_ADDR, 8'hFF);
    end
    $display("test random clears done");
    hold(4);
    `CHK(exp_q.size(), 0)
    tally_and_finish();
  end
endmodule : fault_thermal_status_bank_tb_top

`default_nettype wire
